/* File: rtl/fault_pg_defs.vh */
/*
 Register offsets, field positions and reset values of the fault-mask and
 output-one power-good tree registers.
 Assumes: included by bare name by the design files.
*/
`ifndef FAULT_PG_DEFS_VH
`define FAULT_PG_DEFS_VH

`define RAIL_FAULT_MASK_B_OFS 8'hA3
`define PG_OUTPUT_ONE_TREE_A_OFS 8'hA4

`define RAIL_FAULT_MASK_B_RST 8'h3F
`define PG_OUTPUT_ONE_TREE_A_RST 8'hC2

// Fault mask fields
`define AUX_LINEAR_ONE_FAULT_MASK 4
`define TERMINATION_LINEAR_FAULT_MASK 3
`define LOAD_SWITCH_B_SECOND_FAULT_MASK 2
`define LOAD_SWITCH_B_FIRST_FAULT_MASK 1
`define AUX_LINEAR_THREE_FAULT_MASK 0
`define FAULT_MASK_WIDTH 5
`define FAULT_RSVD_VALUE 3'h1

// Output-one tree fields
`define AUX_LINEAR_TWO_TREE_EXCLUDE 7
`define LOAD_SWITCH_A_FIRST_TREE_EXCLUDE 6
`define STEP_DOWN_SIX_TREE_EXCLUDE 5
`define STEP_DOWN_ONE_TREE_EXCLUDE 0
`define TREE_WIDTH 8

`endif

/* File: rtl/masked_combine.v */
/*
 Synchronises a group of rail status pins and combines them under a mask.
 ANY_MODE=1: output is high when any unmasked input is high (faults).
 ANY_MODE=0: output is high when every unmasked input is high (power good).
 Assumes: inputs are asynchronous pins; one clock, reset already synchronised.
*/
`timescale 1ns/10ps
module masked_combine #(
    parameter WIDTH = 8,
    parameter ANY_MODE = 0
) (
    input wire clock,
    input wire rst_sync_n,
    input wire [WIDTH-1:0] raw,
    input wire [WIDTH-1:0] mask,
    output reg result_q
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;
    wire [WIDTH-1:0] term;
    genvar i;

    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always @(posedge clock or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end
                else
                begin
                    meta_q[i] <= raw[i];
                    sync_q[i] <= meta_q[i];
                end
            end
            // Masked bit drops out: forced low for faults, high for the tree
            if (ANY_MODE != 0)
            begin : g_any
                assign term[i] = sync_q[i] & ~mask[i];
            end
            else
            begin : g_all
                assign term[i] = sync_q[i] | mask[i];
            end
        end
    endgenerate

    always @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            result_q <= 1'b0;
        else if (ANY_MODE != 0)
            result_q <= |term;
        else
            result_q <= &term;
    end
endmodule

/* File: rtl/fault_mask_and_pg_tree_regs.v */
/*
 Fault-mask register and output-one power-good tree selector, with the
 shutdown gating and power-good aggregation they steer.
 Assumes: the serial register engine presents accesses on the same clock as
 one-cycle strobes; rail fault and power-good pins are asynchronous.
*/
// How it works
// - Masked rail fault never requests shutdown.
// - Fault masks at bits four down to zero.
// - Fault mask at A3 resets 3F, top reserved.
// - Tree bit zero includes rail, one excludes.
// - Tree bits: aux two, switch a, step-downs.
// - Tree selector at A4 resets to C2.
// - All mask bits read/write, effective immediately.
`timescale 1ns/10ps
`include "fault_pg_defs.vh"
module fault_mask_and_pg_tree_regs (
    input wire clock,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    input wire [`FAULT_MASK_WIDTH-1:0] rail_fault,
    input wire [`TREE_WIDTH-1:0] rail_pg,
    output wire shutdown_req_q,
    output wire pg_output_one_q
);
    // Only the five stored masks take the reset pattern; the reserved bits are fixed
    localparam [7:0] FAULT_RST = `RAIL_FAULT_MASK_B_RST;
    reg rst_meta_q;
    reg rst_sync_n;
    reg [`FAULT_MASK_WIDTH-1:0] fault_mask_q;
    reg [`TREE_WIDTH-1:0] tree_exclude_q;
    wire [7:0] fault_reg_value;

    // Reset asserts at once, releases two edges later
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // Reserved bits are fixed; only the five masks store
    assign fault_reg_value = {`FAULT_RSVD_VALUE, fault_mask_q};

    always @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            fault_mask_q <= FAULT_RST[`FAULT_MASK_WIDTH-1:0];
            tree_exclude_q <= `PG_OUTPUT_ONE_TREE_A_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `RAIL_FAULT_MASK_B_OFS)
                fault_mask_q <= reg_wdata[`AUX_LINEAR_ONE_FAULT_MASK:`AUX_LINEAR_THREE_FAULT_MASK];
            if (reg_addr == `PG_OUTPUT_ONE_TREE_A_OFS)
                tree_exclude_q <= reg_wdata;
        end
    end

    // Unmapped offsets read as zero
    always @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `RAIL_FAULT_MASK_B_OFS: reg_rdata_q <= fault_reg_value;
                `PG_OUTPUT_ONE_TREE_A_OFS: reg_rdata_q <= tree_exclude_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // Masks act combinationally on the synchronised pins, so a write counts at once
    masked_combine #(
        .WIDTH(`FAULT_MASK_WIDTH),
        .ANY_MODE(1)
    ) u_fault (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .raw(rail_fault),
        .mask(fault_mask_q),
        .result_q(shutdown_req_q)
    );

    // All excluded gives constant good, as the AND of all ones
    masked_combine #(
        .WIDTH(`TREE_WIDTH),
        .ANY_MODE(0)
    ) u_tree (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .raw(rail_pg),
        .mask(tree_exclude_q),
        .result_q(pg_output_one_q)
    );
endmodule

/* File: sim/fault_pg_monitor.sv */
/* Port checks for the fault mask and tree block.
   Assumes bind to its top; pins take 3 edges, mask writes 2. */
`timescale 1ns/10ps
module fault_pg_monitor (
    input wire clock,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire [4:0] rail_fault,
    input wire [7:0] rail_pg,
    input wire shutdown_req_q,
    input wire pg_output_one_q
);
    reg [4:0] fm_q;
    reg [7:0] tm_q;
    reg [2:0] up_q;
    // Shadow masks; checks wait until the reset synchroniser has let go
    always @(posedge clock or negedge rst_n)
        if (!rst_n)
            {up_q, fm_q, tm_q} <= {3'h0, 5'h1f, 8'hc2};
        else
        begin
            up_q <= up_q + {2'h0, up_q != 3'h7};
            if (reg_wr && reg_addr == 8'ha3)
                fm_q <= reg_wdata[4:0];
            if (reg_wr && reg_addr == 8'ha4)
                tm_q <= reg_wdata;
        end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n || up_q != 3'h7);
    shut_gate_a: assert property (shutdown_req_q == |($past(rail_fault, 3) & ~$past(fm_q)))
        else $error("shutdown wrong");
    pg_tree_a: assert property (pg_output_one_q == &($past(rail_pg, 3) | $past(tm_q)))
        else $error("pg wrong");
    fault_read_a: assert property (reg_rd && reg_addr == 8'ha3 |=> reg_rdata_q == {3'h1, $past(fm_q)})
        else $error("a3 read wrong");
    tree_read_a: assert property (reg_rd && reg_addr == 8'ha4 |=> reg_rdata_q == $past(tm_q))
        else $error("a4 read wrong");
    other_read_a: assert property (reg_rd && reg_addr != 8'ha3 && reg_addr != 8'ha4 |=> reg_rdata_q == 8'h00)
        else $error("other read wrong");
    read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved");
    all_masked_a: assert property ($past(fm_q) == 5'h1f |-> !shutdown_req_q)
        else $error("masked fault shut");
    empty_tree_a: assert property ($past(tm_q) == 8'hff |-> pg_output_one_q)
        else $error("empty tree low");
    cover property ($rose(shutdown_req_q));
    cover property ($fell(pg_output_one_q));
    cover property (reg_wr && reg_addr == 8'ha4);
endmodule
bind fault_mask_and_pg_tree_regs fault_pg_monitor u_fault_pg_monitor (.*);

/* File: sim/test_fault_mask_and_pg_tree_regs.sv */
/* Bench: reads, random and corner writes, random pins.
   Assumes design and monitor compiled first. */
`timescale 1ns/10ps
module test_fault_mask_and_pg_tree_regs;
    reg clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    reg [7:0] reg_addr = 0, reg_wdata = 0, rail_pg = 0, fm = 8'h3f, tm = 8'hc2;
    reg [4:0] rail_fault = 0;
    wire [7:0] reg_rdata_q;
    wire shutdown_req_q, pg_output_one_q;
    integer fail_count = 0, cmp_count = 0, cyc = 0, i, r, seed = 32'hc00f;
    fault_mask_and_pg_tree_regs u_fault_mask_and_pg_tree_regs (.*);
    always #25 clock = ~clock;
    task chk(input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("compares %0d bad %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Hang guard, well above the 490 or so cycles the run needs
    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            fail_count = fail_count + 1;
            finish_test;
        end
    end
    task acc(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge clock);
            #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
            @(posedge clock);
            #1 {reg_wr, reg_rd} = 2'b00;
            if (w && a == 8'ha3)
                fm = {3'h1, d[4:0]};
            if (w && a == 8'ha4)
                tm = d;
        end
    endtask
    function [7:0] rexp(input [7:0] a);
        rexp = a == 8'ha3 ? fm : a == 8'ha4 ? tm : 8'h00;
    endfunction
    function [7:0] lv();
        lv = {6'h0, |(rail_fault & ~fm[4:0]), &(rail_pg | tm)};
    endfunction
    initial
    begin
        repeat (12) @(posedge clock);
        #1 rst_n = 1;
        repeat (8) @(posedge clock);
        // Reads first, so A3 and A4 show reset values; then all-ones tree, all faults unmasked
        for (i = 0; i < 60; i = i + 1)
        begin
            acc(0, 8'ha2 + i % 4, 0);
            chk(reg_rdata_q, rexp(8'ha2 + i % 4));
            r = $random(seed);
            if (i > 2)
                acc(1, i < 5 ? 8'ha7 - i : 8'ha3 + r[9:8], i == 3 ? 8'hff : i == 4 ? 8'h00 : r[7:0]);
            {rail_fault, rail_pg} = i == 3 ? 13'h0 : r[22:10];
            repeat (4) @(posedge clock);
            #1 chk({6'h0, shutdown_req_q, pg_output_one_q}, lv());
            $display("test %0d done", i);
        end
        finish_test;
    end
endmodule
